// [src/rtpt_regs.svh]
`ifndef RTPT_REGS_SVH
`define RTPT_REGS_SVH
// Register offsets
`define RTPT_OFS_PHASE 8'h1E
`define RTPT_OFS_GAIN 8'h1F
`define RTPT_OFS_SLEEP 8'h20
`define RTPT_OFS_DACPMP 8'h21
`define RTPT_OFS_LOOPVCO 8'h22
`define RTPT_OFS_VCOCUR 8'h23
`define RTPT_OFS_PMPMIX 8'h24
`define RTPT_OFS_ADCTST 8'h25
// Reset values
`define RTPT_RST_PHASE 8'h00
`define RTPT_RST_GAIN 8'h00
`define RTPT_RST_SLEEP 8'h00
`define RTPT_RST_DACPMP 8'h4D
`define RTPT_RST_LOOPVCO 8'h10
`define RTPT_RST_VCOCUR 8'h06
`define RTPT_RST_PMPMIX 8'h00
`define RTPT_RST_ADCTST 8'h40
// Field positions
`define RTPT_BIT_LOOP_OPEN 7
`define RTPT_BIT_PUMP_FORCE 6
`define RTPT_BIT_BAND_FORCE 5
`define RTPT_BIT_MANUAL_CAL 7
`define RTPT_BIT_CUR_FORCE 6
`define RTPT_BIT_PUMP_OFF 7
`define RTPT_BIT_PUMP_UP 6
`define RTPT_BIT_PUMP_DN 5
`define RTPT_BIT_MIX_TEST 2
`define RTPT_BIT_FILT_TEST 1
`define RTPT_BIT_CONV_TEST 0
`define RTPT_BIT_FCOMP 7
`define RTPT_BIT_DITHER 6
`define RTPT_BIT_ADC_OUT 5
`define RTPT_BIT_CHOP_OFF 4
`define RTPT_BIT_SHAPE_OFF 3
`define RTPT_BIT_ROT_OFF 2
`define RTPT_MODE_MANUAL 2'h2
`endif

// [src/rtpt_pkg.sv]
package rtpt_pkg;
  // Analog override bundle
  typedef struct packed {
    logic loop_open;
    logic [3:0] cal_dac;
    logic [3:0] pump_current;
    logic [4:0] osc_band;
    logic [5:0] osc_current;
    logic pump_normal_off_bit;
    logic pump_force_up_bit;
    logic pump_force_down_bit;
    logic mixer_dc_test_bit;
    logic [1:0] mixer_forced_polarity;
    logic test_connect;
    logic analog_test_sleep;
    logic [2:0] test_mode;
  } rtpt_ana_s;
  // Calibration inputs
  typedef struct packed {
    logic [3:0] pump_current;
    logic [4:0] osc_band;
    logic [5:0] osc_current;
  } rtpt_cal_s;
  // Rotation selection
  typedef enum logic [1:0] {
    RTPT_ROT_FULL = 2'b00,
    RTPT_ROT_ALT = 2'b01,
    RTPT_ROT_HOLD = 2'b10,
    RTPT_ROT_PAIR = 2'b11
  } rtpt_rot_e;
endpackage

// [src/rtpt_top.sv]
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`include "rtpt_regs.svh"
// How it works
// - Phase trim is signed, about +-6.2 degrees
// - Gain trim is signed, about +-1.16 dB
// - Sleep bits act only in mode 2
// - Sleep bits: amp down to converter order
// - Loop open drives DAC override field
// - Pump force selects forced pump current
// - Band force selects forced oscillator band
// - Current force applies unless manual cal
// - Falling force bit samples cal comparator, only while manual cal is set
// - Pump test bits are independent, reset zero
// - Mixer polarity: bit1 I, bit0 Q
// - Test connect routes interface nibble, else forced
// - Frequency comparator output gated by enable
// - Dither enable resets to one
// - ADC test output steers pins
// - Three ADC disable bits, reset zero
// - Rotation field picks input sequence
module rtpt_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic [1:0] sleep_mode_select,
  input wire logic [3:0] interface_nibble,
  input wire rtpt_pkg::rtpt_cal_s cal_in,
  input wire logic osc_cal_comparator,
  input wire logic freq_comp_raw,
  input wire logic adc_sample,
  input wire logic adc_clk,
  input wire logic lock_normal,
  input wire logic dio_normal,
  input wire logic data_clock_pin_normal,
  output logic signed [7:0] iq_phase_out,
  output logic signed [7:0] iq_gain_out,
  output logic [7:0] block_sleep,
  output rtpt_pkg::rtpt_ana_s ana,
  output logic osc_cal_result,
  output logic freq_comp_out,
  output logic dither_en,
  output logic lock_pin,
  output logic data_io_pin,
  output logic data_clock_pin,
  output logic integrator_chop_off_bit,
  output logic shaping_off,
  output logic common_mode_rotation_off_bit,
  output logic [1:0] adc_rot_pos
);

  // Register storage, one byte each
  logic [7:0] phase_q, gain_q, sleep_q, dacpmp_q, loopvco_q, vcocur_q, pmpmix_q, adctst_q;
  logic [7:0] rdata_q, rdata_d;
  // Synchronisers for the mode pins, three stages
  logic [1:0] mode_s1_q, mode_s2_q, mode_s3_q, mode_q;
  // Synchroniser for the cal comparator input only, three stages
  logic cmp_s1_q, cmp_s2_q, cmp_s3_q, cmp_q;
  // Previous force-bit value for edge detection
  logic cur_force_prev_q;
  // Rotation step counter
  logic [1:0] rot_step_q;
  logic [1:0] rot_pos_d;
  rtpt_pkg::rtpt_ana_s ana_d;
  logic [7:0] sleep_d;
  logic test_on;
  logic cal_fall;

  // Write decodes
  wire wr_phase = wr_stb && addr == `RTPT_OFS_PHASE;
  wire wr_gain = wr_stb && addr == `RTPT_OFS_GAIN;
  wire wr_sleep = wr_stb && addr == `RTPT_OFS_SLEEP;
  wire wr_dacpmp = wr_stb && addr == `RTPT_OFS_DACPMP;
  wire wr_loopvco = wr_stb && addr == `RTPT_OFS_LOOPVCO;
  wire wr_vcocur = wr_stb && addr == `RTPT_OFS_VCOCUR;
  wire wr_pmpmix = wr_stb && addr == `RTPT_OFS_PMPMIX;
  wire wr_adctst = wr_stb && addr == `RTPT_OFS_ADCTST;

  // Registers hold until rewritten
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= `RTPT_RST_PHASE;
      gain_q <= `RTPT_RST_GAIN;
      sleep_q <= `RTPT_RST_SLEEP;
      dacpmp_q <= `RTPT_RST_DACPMP;
      loopvco_q <= `RTPT_RST_LOOPVCO;
      vcocur_q <= `RTPT_RST_VCOCUR;
      pmpmix_q <= `RTPT_RST_PMPMIX;
      adctst_q <= `RTPT_RST_ADCTST;
    end else begin
      if (wr_phase) phase_q <= wdata;
      if (wr_gain) gain_q <= wdata;
      if (wr_sleep) sleep_q <= wdata;
      if (wr_dacpmp) dacpmp_q <= wdata;
      if (wr_loopvco) loopvco_q <= wdata;
      if (wr_vcocur) vcocur_q <= wdata;
      if (wr_pmpmix) pmpmix_q <= wdata;
      if (wr_adctst) adctst_q <= wdata;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (addr)
      `RTPT_OFS_PHASE: rdata_d = phase_q;
      `RTPT_OFS_GAIN: rdata_d = gain_q;
      `RTPT_OFS_SLEEP: rdata_d = sleep_q;
      `RTPT_OFS_DACPMP: rdata_d = dacpmp_q;
      `RTPT_OFS_LOOPVCO: rdata_d = loopvco_q;
      `RTPT_OFS_VCOCUR: rdata_d = vcocur_q;
      `RTPT_OFS_PMPMIX: rdata_d = pmpmix_q;
      `RTPT_OFS_ADCTST: rdata_d = adctst_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Pin inputs cross in; change counts when stages 2 and 3 agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
      mode_s3_q <= 2'h0;
      mode_q <= 2'h0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      cmp_s3_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      mode_s1_q <= sleep_mode_select;
      mode_s2_q <= mode_s1_q;
      mode_s3_q <= mode_s2_q;
      if (mode_s2_q == mode_s3_q) mode_q <= mode_s3_q;
      cmp_s1_q <= osc_cal_comparator;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      if (cmp_s2_q == cmp_s3_q) cmp_q <= cmp_s3_q;
    end
  end

  // Sleep bits gated by manual mode; bit order amp..converter
  assign sleep_d = (mode_q == `RTPT_MODE_MANUAL) ? sleep_q : 8'h00;

  // Manual calibration strobe falls: sample comparator
  assign cal_fall = vcocur_q[`RTPT_BIT_MANUAL_CAL] && cur_force_prev_q
                    && !vcocur_q[`RTPT_BIT_CUR_FORCE];

  assign test_on = pmpmix_q[`RTPT_BIT_FILT_TEST] || pmpmix_q[`RTPT_BIT_CONV_TEST];

  // Analog override selection
  always_comb begin
    ana_d.loop_open = loopvco_q[`RTPT_BIT_LOOP_OPEN];
    ana_d.cal_dac = dacpmp_q[7:4];
    ana_d.pump_current = loopvco_q[`RTPT_BIT_PUMP_FORCE] ? dacpmp_q[3:0] : cal_in.pump_current;
    ana_d.osc_band = loopvco_q[`RTPT_BIT_BAND_FORCE] ? loopvco_q[4:0] : cal_in.osc_band;
    // Manual calibration reuses the force bit as a clock, so no override then
    ana_d.osc_current = (vcocur_q[`RTPT_BIT_CUR_FORCE] && !vcocur_q[`RTPT_BIT_MANUAL_CAL])
                        ? vcocur_q[5:0] : cal_in.osc_current;
    ana_d.pump_normal_off_bit = pmpmix_q[`RTPT_BIT_PUMP_OFF];
    ana_d.pump_force_up_bit = pmpmix_q[`RTPT_BIT_PUMP_UP];
    ana_d.pump_force_down_bit = pmpmix_q[`RTPT_BIT_PUMP_DN];
    ana_d.mixer_dc_test_bit = pmpmix_q[`RTPT_BIT_MIX_TEST];
    ana_d.mixer_forced_polarity = pmpmix_q[4:3];
    ana_d.test_connect = test_on;
    ana_d.analog_test_sleep = test_on ? interface_nibble[3] : 1'b1;
    ana_d.test_mode = test_on ? interface_nibble[2:0] : {1'b1, interface_nibble[1:0]};
  end

  // Rotation position per selected pattern
  always_comb begin
    case (rtpt_pkg::rtpt_rot_e'(adctst_q[1:0]))
      rtpt_pkg::RTPT_ROT_FULL: rot_pos_d = rot_step_q;
      rtpt_pkg::RTPT_ROT_ALT: begin
        case (rot_step_q)
          2'h0: rot_pos_d = 2'b00;
          2'h1: rot_pos_d = 2'b10;
          2'h2: rot_pos_d = 2'b11;
          default: rot_pos_d = 2'b01;
        endcase
      end
      rtpt_pkg::RTPT_ROT_HOLD: rot_pos_d = 2'b00;
      rtpt_pkg::RTPT_ROT_PAIR: rot_pos_d = rot_step_q[0] ? 2'b10 : 2'b00;
      default: rot_pos_d = 2'b00;
    endcase
  end

  // Output registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
      cur_force_prev_q <= 1'b0;
      osc_cal_result <= 1'b0;
      rot_step_q <= 2'h0;
      adc_rot_pos <= 2'h0;
      iq_phase_out <= 8'sh00;
      iq_gain_out <= 8'sh00;
      block_sleep <= 8'h00;
      ana <= '0;
      freq_comp_out <= 1'b0;
      dither_en <= 1'b1;
      lock_pin <= 1'b0;
      data_io_pin <= 1'b0;
      data_clock_pin <= 1'b0;
      integrator_chop_off_bit <= 1'b0;
      shaping_off <= 1'b0;
      common_mode_rotation_off_bit <= 1'b0;
    end else begin
      rdata_q <= rd_stb ? rdata_d : 8'h00;
      cur_force_prev_q <= vcocur_q[`RTPT_BIT_CUR_FORCE];
      if (cal_fall) osc_cal_result <= cmp_q;
      // Rotation advances each clock; freezes when disabled
      if (!adctst_q[`RTPT_BIT_ROT_OFF]) rot_step_q <= rot_step_q + 2'h1;
      adc_rot_pos <= rot_pos_d;
      iq_phase_out <= $signed(phase_q);
      iq_gain_out <= $signed(gain_q);
      block_sleep <= sleep_d;
      ana <= ana_d;
      freq_comp_out <= adctst_q[`RTPT_BIT_FCOMP] && freq_comp_raw;
      dither_en <= adctst_q[`RTPT_BIT_DITHER];
      // ADC sample and ADC clock steer the pins in test mode, one cycle latency
      lock_pin <= adctst_q[`RTPT_BIT_ADC_OUT] ? adc_sample : lock_normal;
      data_io_pin <= adctst_q[`RTPT_BIT_ADC_OUT] ? adc_sample : dio_normal;
      data_clock_pin <= adctst_q[`RTPT_BIT_ADC_OUT] ? adc_clk : data_clock_pin_normal;
      integrator_chop_off_bit <= adctst_q[`RTPT_BIT_CHOP_OFF];
      shaping_off <= adctst_q[`RTPT_BIT_SHAPE_OFF];
      common_mode_rotation_off_bit <= adctst_q[`RTPT_BIT_ROT_OFF];
    end
  end

  assign rdata = rdata_q;

  // Assertions
  property p_sleep_gate;
    @(posedge core_clk) disable iff (!rst_b)
      (mode_q != `RTPT_MODE_MANUAL) |=> (block_sleep == 8'h00);
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("sleep bits leak outside manual mode");

  property p_sleep_pass;
    @(posedge core_clk) disable iff (!rst_b)
      (mode_q == `RTPT_MODE_MANUAL) |=> (block_sleep == $past(sleep_q));
  endproperty
  a_sleep_pass: assert property (p_sleep_pass) else $error("sleep bits not applied in manual mode");

  property p_pump_sel;
    @(posedge core_clk) disable iff (!rst_b)
      loopvco_q[`RTPT_BIT_PUMP_FORCE] |=> (ana.pump_current == $past(dacpmp_q[3:0]));
  endproperty
  a_pump_sel: assert property (p_pump_sel) else $error("pump current override ignored");

  property p_band_sel;
    @(posedge core_clk) disable iff (!rst_b)
      !loopvco_q[`RTPT_BIT_BAND_FORCE] |=> (ana.osc_band == $past(cal_in.osc_band));
  endproperty
  a_band_sel: assert property (p_band_sel) else $error("band not calibrated value");

  property p_cur_manual;
    @(posedge core_clk) disable iff (!rst_b)
      vcocur_q[`RTPT_BIT_MANUAL_CAL] |=> (ana.osc_current == $past(cal_in.osc_current));
  endproperty
  a_cur_manual: assert property (p_cur_manual) else $error("current forced during manual cal");

  sequence s_force_fall;
    vcocur_q[`RTPT_BIT_MANUAL_CAL] && vcocur_q[`RTPT_BIT_CUR_FORCE]
      ##1 vcocur_q[`RTPT_BIT_MANUAL_CAL] && !vcocur_q[`RTPT_BIT_CUR_FORCE];
  endsequence
  property p_cal_sample;
    @(posedge core_clk) disable iff (!rst_b)
      s_force_fall |=> (osc_cal_result == $past(cmp_q));
  endproperty
  a_cal_sample: assert property (p_cal_sample) else $error("comparator not sampled on fall");

  property p_test_forced;
    @(posedge core_clk) disable iff (!rst_b)
      !test_on |=> (ana.analog_test_sleep && ana.test_mode[2]);
  endproperty
  a_test_forced: assert property (p_test_forced) else $error("test module not forced off");

  property p_dither;
    @(posedge core_clk) disable iff (!rst_b)
      1'b1 |=> (dither_en == $past(adctst_q[`RTPT_BIT_DITHER]));
  endproperty
  a_dither: assert property (p_dither) else $error("dither enable mismatch");

  property p_rot_hold;
    @(posedge core_clk) disable iff (!rst_b)
      (adctst_q[1:0] == 2'h2) |=> (adc_rot_pos == 2'b00);
  endproperty
  a_rot_hold: assert property (p_rot_hold) else $error("rotation not held at 00");

  property p_readback;
    @(posedge core_clk) disable iff (!rst_b)
      (wr_stb && addr == `RTPT_OFS_PHASE) ##1 (rd_stb && addr == `RTPT_OFS_PHASE && !wr_stb)
        |=> (rdata == $past(wdata, 2));
  endproperty
  a_readback: assert property (p_readback) else $error("readback differs from write");

  property p_loop_dac;
    @(posedge core_clk) disable iff (!rst_b)
      loopvco_q[`RTPT_BIT_LOOP_OPEN] |=> (ana.loop_open && ana.cal_dac == $past(dacpmp_q[7:4]));
  endproperty
  a_loop_dac: assert property (p_loop_dac) else $error("open loop without DAC override");

  property p_pump_cal;
    @(posedge core_clk) disable iff (!rst_b)
      !loopvco_q[`RTPT_BIT_PUMP_FORCE] |=> (ana.pump_current == $past(cal_in.pump_current));
  endproperty
  a_pump_cal: assert property (p_pump_cal) else $error("pump current not calibrated value");

  property p_band_force;
    @(posedge core_clk) disable iff (!rst_b)
      loopvco_q[`RTPT_BIT_BAND_FORCE] |=> (ana.osc_band == $past(loopvco_q[4:0]));
  endproperty
  a_band_force: assert property (p_band_force) else $error("band override ignored");

  property p_cur_force;
    @(posedge core_clk) disable iff (!rst_b)
      (vcocur_q[`RTPT_BIT_CUR_FORCE] && !vcocur_q[`RTPT_BIT_MANUAL_CAL])
        |=> (ana.osc_current == $past(vcocur_q[5:0]));
  endproperty
  a_cur_force: assert property (p_cur_force) else $error("current override ignored");

  property p_test_route;
    @(posedge core_clk) disable iff (!rst_b)
      test_on |=> (ana.test_connect && {ana.analog_test_sleep, ana.test_mode} == $past(interface_nibble));
  endproperty
  a_test_route: assert property (p_test_route) else $error("interface nibble not routed to test module");

  property p_fcomp_off;
    @(posedge core_clk) disable iff (!rst_b)
      !adctst_q[`RTPT_BIT_FCOMP] |=> !freq_comp_out;
  endproperty
  a_fcomp_off: assert property (p_fcomp_off) else $error("comparator output leaks while disabled");

  property p_adc_pins;
    @(posedge core_clk) disable iff (!rst_b)
      adctst_q[`RTPT_BIT_ADC_OUT] |=> (lock_pin == $past(adc_sample) && data_io_pin == $past(adc_sample)
        && data_clock_pin == $past(adc_clk));
  endproperty
  a_adc_pins: assert property (p_adc_pins) else $error("converter test output not on pins");

  property p_rdata_idle;
    @(posedge core_clk) disable iff (!rst_b)
      !rd_stb |=> (rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

endmodule

// [verif/test_radio_trim_block_sleep_control_test_regs.sv]
`timescale 1ns/10ps
`include "rtpt_regs.svh"
module test_radio_trim_block_sleep_control_test_regs;
  // Clock, reset and register bus
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  // Side inputs, all driven so no logic behind them is left dead
  logic [1:0] sleep_mode_select = 2'h0;
  logic [3:0] interface_nibble = 4'h0;
  rtpt_pkg::rtpt_cal_s cal_in = '{pump_current: 4'h3, osc_band: 5'h0A, osc_current: 6'h21};
  logic osc_cal_comparator = 1'b0;
  logic freq_comp_raw = 1'b0, adc_sample = 1'b0, adc_clk = 1'b0;
  logic lock_normal = 1'b0, dio_normal = 1'b0, data_clock_pin_normal = 1'b0;
  // Outputs
  logic [7:0] rdata, block_sleep;
  logic signed [7:0] iq_phase_out, iq_gain_out;
  rtpt_pkg::rtpt_ana_s ana;
  logic osc_cal_result, freq_comp_out, dither_en, lock_pin, data_io_pin, data_clock_pin;
  logic chop_off, shaping_off, rot_off;
  logic [1:0] adc_rot_pos;
  // Scoreboard
  int error_cnt = 0;
  int cmp_count = 0;
  int i;
  int j;
  int p;
  logic [1:0] prev_pos;
  // Rotation sequences per pattern, in the order the positions must follow each other
  logic [1:0] rot_seq [4][4] = '{'{2'b00, 2'b01, 2'b10, 2'b11}, '{2'b00, 2'b10, 2'b11, 2'b01},
                                 '{2'b00, 2'b00, 2'b00, 2'b00}, '{2'b00, 2'b10, 2'b00, 2'b10}};
  // Rows: address, written byte, expected read-back; 1D and 26 are unmapped
  logic [23:0] rows [10] = '{24'h1E_8080, 24'h1F_7F7F, 24'h20_A5A5, 24'h21_5A5A, 24'h22_3333,
                             24'h23_3F3F, 24'h24_1818, 24'h25_0303, 24'h26_5A00, 24'h1D_FF00};
  logic [7:0] rstv [8] = '{`RTPT_RST_PHASE, `RTPT_RST_GAIN, `RTPT_RST_SLEEP, `RTPT_RST_DACPMP,
                           `RTPT_RST_LOOPVCO, `RTPT_RST_VCOCUR, `RTPT_RST_PMPMIX, `RTPT_RST_ADCTST};

  // Free-running 100 MHz clock
  always #5 core_clk = ~core_clk;

  rtpt_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .sleep_mode_select(sleep_mode_select), .interface_nibble(interface_nibble),
    .cal_in(cal_in), .osc_cal_comparator(osc_cal_comparator), .freq_comp_raw(freq_comp_raw),
    .adc_sample(adc_sample), .adc_clk(adc_clk), .lock_normal(lock_normal), .dio_normal(dio_normal),
    .data_clock_pin_normal(data_clock_pin_normal), .iq_phase_out(iq_phase_out), .iq_gain_out(iq_gain_out),
    .block_sleep(block_sleep), .ana(ana), .osc_cal_result(osc_cal_result), .freq_comp_out(freq_comp_out),
    .dither_en(dither_en), .lock_pin(lock_pin), .data_io_pin(data_io_pin), .data_clock_pin(data_clock_pin),
    .integrator_chop_off_bit(chop_off), .shaping_off(shaping_off), .common_mode_rotation_off_bit(rot_off),
    .adc_rot_pos(adc_rot_pos));

  // One compare for every byte-sized result; narrow fields are widened by the caller
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; the strobe drops one edge later, so calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe, so it is sampled just past that edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Let registered outputs settle; synchronised pins need the longer wait
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic give_verdict;
    $display("TB: errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    // Table rows: write, then read back; unmapped places read zero
    for (i = 0; i < 10; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    wt(1);
    chk(iq_phase_out, 8'h80);
    chk(iq_gain_out, 8'h7F);
    // Reset in mid-run must bring every register back to its default
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) rdc(8'h1E + 8'(i), rstv[i]);
    wt(1);
    chk(8'(dither_en), 8'h01);
    chk(block_sleep, 8'h00);
    // Write and read with no gap between the strobes; data stands one cycle only
    wr(`RTPT_OFS_PHASE, 8'h5A);
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, 8'h5A);
    wt(1);
    chk(rdata, 8'h00);
    chk(iq_phase_out, 8'h5A);
    // Sleep bits only reach the blocks in mode 2; an asymmetric pattern catches a reversed order
    wr(`RTPT_OFS_SLEEP, 8'hC1);
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      sleep_mode_select <= 2'(i);
      wt(6);
      chk(block_sleep, (i == 2) ? 8'hC1 : 8'h00);
    end
    // Forced values against calibrated ones
    wr(`RTPT_OFS_LOOPVCO, 8'hF3);
    wt(2);
    chk({ana.loop_open, 3'h0, ana.cal_dac}, 8'h84);
    chk(8'(ana.pump_current), 8'h0D);
    chk(8'(ana.osc_band), 8'h13);
    wr(`RTPT_OFS_LOOPVCO, 8'h13);
    wt(2);
    chk(8'(ana.loop_open), 8'h00);
    chk(8'(ana.pump_current), 8'h03);
    chk(8'(ana.osc_band), 8'h0A);
    wr(`RTPT_OFS_VCOCUR, 8'h46);
    wt(2);
    chk(8'(ana.osc_current), 8'h06);
    // Manual calibration: force bit acts as the strobe, falling edge samples
    @(posedge core_clk);
    osc_cal_comparator <= 1'b1;
    wr(`RTPT_OFS_VCOCUR, 8'hC6);
    wt(6);
    chk(8'(ana.osc_current), 8'h21);
    chk(8'(osc_cal_result), 8'h00);
    wr(`RTPT_OFS_VCOCUR, 8'h86);
    wt(3);
    chk(8'(osc_cal_result), 8'h01);
    @(posedge core_clk);
    osc_cal_comparator <= 1'b0;
    wr(`RTPT_OFS_VCOCUR, 8'hC6);
    wt(6);
    chk(8'(osc_cal_result), 8'h01);
    wr(`RTPT_OFS_VCOCUR, 8'h86);
    wt(3);
    chk(8'(osc_cal_result), 8'h00);
    // Pump test bits and every mixer polarity
    for (i = 0; i < 4; i++) begin
      wr(`RTPT_OFS_PMPMIX, {3'b111, 2'(i), 3'b100});
      wt(2);
      chk({2'h0, ana.pump_normal_off_bit, ana.pump_force_up_bit, ana.pump_force_down_bit,
           ana.mixer_forced_polarity, ana.mixer_dc_test_bit}, {2'h0, 3'b111, 2'(i), 1'b1});
    end
    // Test module routing: forced when neither input is connected
    @(posedge core_clk);
    interface_nibble <= 4'h2;
    wr(`RTPT_OFS_PMPMIX, 8'h00);
    wt(2);
    chk(8'({ana.test_connect, ana.analog_test_sleep, ana.test_mode}), 8'h0E);
    wr(`RTPT_OFS_PMPMIX, 8'h01);
    wt(2);
    chk(8'({ana.test_connect, ana.analog_test_sleep, ana.test_mode}), 8'h12);
    @(posedge core_clk);
    interface_nibble <= 4'hA;
    wr(`RTPT_OFS_PMPMIX, 8'h02);
    wt(2);
    chk(8'({ana.test_connect, ana.analog_test_sleep, ana.test_mode}), 8'h1A);
    // Converter test output steers the pins; normal levels are set opposite
    @(posedge core_clk);
    freq_comp_raw <= 1'b1;
    adc_sample <= 1'b1;
    data_clock_pin_normal <= 1'b1;
    wr(`RTPT_OFS_ADCTST, 8'hA0);
    wt(2);
    chk({3'h0, freq_comp_out, dither_en, lock_pin, data_io_pin, data_clock_pin}, 8'h16);
    wr(`RTPT_OFS_ADCTST, 8'h1C);
    wt(2);
    chk({3'h0, freq_comp_out, dither_en, lock_pin, data_io_pin, data_clock_pin}, 8'h01);
    chk({5'h0, chop_off, shaping_off, rot_off}, 8'h07);
    // Every rotation pattern: each position must be followed by the next one of its sequence
    for (p = 0; p < 4; p++) begin
      wr(`RTPT_OFS_ADCTST, 8'h40 | 8'(p));
      wt(2);
      for (i = 0; i < 4; i++) begin
        prev_pos = adc_rot_pos;
        j = 0;
        while (j < 3 && rot_seq[p][j] != prev_pos) j++;
        wt(1);
        chk(8'(adc_rot_pos), 8'(rot_seq[p][(j + 1) % 4]));
      end
    end
    give_verdict();
  end
endmodule
